/* rtl/pae_accumulator.sv */
// How it works
// RL1 - Reverse bits 12..14 of pulse numerator register show phase A/B/C sign.
// RL2 - A phase is reverse when its active power is negative.
// RL3 - An excluded phase always reports zero in its reverse bit.
// RL4 - Mode bit 5 enables phase A term and its reverse reporting.
// RL5 - Mode bits 7:6 select the total power formula.
// RL6 - Each term enable includes its term, or zero when cleared.
// RL7 - Formula 0 sums all; 1 uses A-B and C-B; 2 uses A-B and C.
// RL8 - Current operands are gain corrected, high-pass filtered samples.
// RL9 - Total power integrates into a hidden 54-bit accumulator.
// RL10 - One sample is added every four input clocks.
// RL11 - Accumulation is signed; negative power lowers energy.
// RL12 - Accumulator divided by 8-bit divisor; zero acts as one.
// RL13 - Readable energy is upper 24 bits of the quotient.
// RL14 - Clear-on-read returns value then clears the accumulator.
// RL15 - Plain read returns value, accumulator untouched.
// RL16 - Energy value wraps through full scale in both directions; here it wraps at full scale divided by the divisor (zero as one).
// RL17 - Enabled interrupt when energy reaches half full scale.
// RL18 - Host keeps phase gains default in formula 0, calibrates watt gain.
// RL19 - Host picks formula and enables matching the wiring.
// RL20 - One internal pulse per energy LSB, scaled by numerator/denominator.
// RL21 - A sample arriving with a clear-on-read is kept after the clear.
`timescale 1ns/1ps
module pae_accumulator (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [pae_pkg::SAMP_W-1:0] volt_a_in,
  input wire logic [pae_pkg::SAMP_W-1:0] volt_b_in,
  input wire logic [pae_pkg::SAMP_W-1:0] volt_c_in,
  input wire logic [pae_pkg::SAMP_W-1:0] cur_a_in,
  input wire logic [pae_pkg::SAMP_W-1:0] cur_b_in,
  input wire logic [pae_pkg::SAMP_W-1:0] cur_c_in,
  input wire logic [pae_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic reg_wr_in,
  input wire logic [pae_pkg::EN_W-1:0] reg_wdata_in,
  output logic [pae_pkg::EN_W-1:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic half_full_irq_out,
  output logic cf_pulse_out
);
  import pae_pkg::*;

  typedef struct packed {
    logic [1:0] cnt;
    logic [ACC_W-1:0] acc;
    logic [EN_W-1:0] energy;
    logic [7:0] mode;
    logic [DIV_W-1:0] divisor;
    logic [CF_W-1:0] pulse_num;
    logic [CF_W-1:0] pulse_den;
    logic irq_en;
    logic hf_stat;
    logic hf_prev;
    logic [2:0] rev;
    logic [EN_W-1:0] rdata;
    logic rvalid;
    logic div_start;
    logic [EN_W:0] pend;
    logic [CF_W:0] cf_acc;
    logic cf_pulse;
    logic irq;
  } pae_acc_st_type;

  localparam pae_acc_st_type ST_RST = '{
    mode: MODE_RST,
    divisor: DIVISOR_RST,
    pulse_num: PULSE_NUM_RST,
    pulse_den: PULSE_DEN_RST,
    irq_en: IRQ_EN_RST,
    div_start: 1'b1,
    default: '0
  };

  pae_acc_st_type st_r;
  pae_acc_st_type st_nxt;

  function automatic logic signed [TERM_W-1:0] sx(input logic [SAMP_W-1:0] v);
    sx = {{(TERM_W - SAMP_W){v[SAMP_W-1]}}, v};
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction

  logic signed [TERM_W-1:0] pwr_a;
  logic signed [TERM_W-1:0] pwr_b;
  logic signed [TERM_W-1:0] pwr_c;
  logic signed [TERM_W-1:0] term_a;
  logic signed [TERM_W-1:0] term_b;
  logic signed [TERM_W-1:0] term_c;
  logic signed [TERM_W-1:0] total;
  logic [ACC_W-1:0] total_ext;
  logic [1:0] form;
  logic en_a;
  logic en_b;
  logic en_c;
  logic sum_form;
  logic add_now;
  logic rd_plain;
  logic rd_clear;
  logic rd_stat;
  logic hf_now;
  logic [DIV_W-1:0] div_eff;
  logic [ACC_W-1:0] div_q;
  logic div_done;

  // Operands already carry gain correction and high-pass filtering see RL8
  assign pwr_a = sx(volt_a_in) * sx(cur_a_in);
  assign pwr_b = sx(volt_b_in) * sx(cur_b_in);
  assign pwr_c = sx(volt_c_in) * sx(cur_c_in);

  assign form = st_r.mode[MODE_FORM_HI:MODE_FORM_LO]; // see RL5
  assign en_a = st_r.mode[MODE_TERM_A]; // see RL4
  assign en_b = st_r.mode[MODE_TERM_B];
  assign en_c = st_r.mode[MODE_TERM_C];
  assign sum_form = (form != FORM_DIFF) && (form != FORM_MIXED);

  // Formula selection with per-term enables see RL6 see RL7
  assign term_a = !en_a ? '0 :
                  sum_form ? pwr_a : sx(volt_a_in) * (sx(cur_a_in) - sx(cur_b_in));
  assign term_b = (en_b && sum_form) ? pwr_b : '0;
  assign term_c = !en_c ? '0 :
                  (form == FORM_DIFF) ? sx(volt_c_in) * (sx(cur_c_in) - sx(cur_b_in)) :
                  pwr_c;
  assign total = term_a + term_b + term_c;
  assign total_ext = {{(ACC_W - TERM_W){total[TERM_W-1]}}, total};

  assign add_now = (st_r.cnt == ACC_LAST); // see RL10
  assign rd_plain = reg_rd_in && hit(reg_addr_in, OFS_ENERGY);
  assign rd_clear = reg_rd_in && hit(reg_addr_in, OFS_ENERGY_RC);
  assign rd_stat = reg_rd_in && hit(reg_addr_in, OFS_IRQ_STAT);
  assign hf_now = st_r.energy[EN_W-1] ^ st_r.energy[EN_W-2];
  assign div_eff = (st_r.divisor == '0) ? 8'h01 : st_r.divisor; // see RL12

  pae_divider #(
    .N_W(ACC_W),
    .D_W(DIV_W)
  ) u_divider (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .start_in(st_r.div_start),
    .num_in(st_r.acc),
    .den_in(div_eff),
    .quot_out(div_q),
    .done_out(div_done)
  );

  always_comb begin
    logic [EN_W-1:0] delta;
    logic [EN_W-1:0] mag;
    logic [CF_W:0] cf_sum;
    logic [CF_W-1:0] num_eff;
    logic [CF_W-1:0] den_eff;
    delta = '0;
    mag = '0;
    cf_sum = '0;
    num_eff = (st_r.pulse_num == '0) ? 12'h001 : st_r.pulse_num;
    den_eff = (st_r.pulse_den == '0) ? 12'h001 : st_r.pulse_den;
    st_nxt = st_r;
    st_nxt.cnt = st_r.cnt + 2'h1;
    st_nxt.cf_pulse = 1'b0;

    // Signed integration, wrapping in two's complement see RL9 see RL11
    if (rd_clear) begin
      st_nxt.acc = add_now ? total_ext : '0; // see RL14 see RL21
    end else if (add_now) begin
      st_nxt.acc = st_r.acc + total_ext; // see RL16
    end

    // Quotient restarts after each result and after a clear
    // A result finishing just after a clear is stale and dropped see RL14
    st_nxt.div_start = div_done || rd_clear;
    if (rd_clear) begin
      st_nxt.energy = '0;
    end else if (div_done && !st_r.div_start) begin
      st_nxt.energy = div_q[ACC_W-1:ACC_W-EN_W]; // see RL13
      delta = st_nxt.energy - st_r.energy;
      mag = delta[EN_W-1] ? -delta : delta;
    end

    // One internal pulse per energy LSB, then rate scaling see RL20
    if (st_r.pend != '0) begin
      st_nxt.pend = st_r.pend + {1'b0, mag} - 25'h0000001;
      cf_sum = st_r.cf_acc + {1'b0, num_eff};
      if (cf_sum >= {1'b0, den_eff}) begin
        st_nxt.cf_acc = cf_sum - {1'b0, den_eff};
        st_nxt.cf_pulse = 1'b1;
      end else begin
        st_nxt.cf_acc = cf_sum;
      end
    end else begin
      st_nxt.pend = st_r.pend + {1'b0, mag};
    end

    // Reverse power follows sign, forced low when phase excluded see RL1 see RL2 see RL3
    st_nxt.rev[0] = en_a && pwr_a[TERM_W-1];
    st_nxt.rev[1] = en_b && pwr_b[TERM_W-1];
    st_nxt.rev[2] = en_c && pwr_c[TERM_W-1];

    // Half-full flag; a new crossing beats the clearing read see RL17
    st_nxt.hf_prev = hf_now;
    st_nxt.hf_stat = (hf_now && !st_r.hf_prev) || (st_r.hf_stat && !rd_stat);
    st_nxt.irq = st_r.irq_en && st_nxt.hf_stat;

    st_nxt.rvalid = reg_rd_in;
    if (reg_rd_in) begin
      case (reg_addr_in)
        OFS_ENERGY: st_nxt.rdata = st_r.energy; // see RL15
        OFS_ENERGY_RC: st_nxt.rdata = st_r.energy; // see RL14
        OFS_DIVISOR: st_nxt.rdata = {16'h0000, st_r.divisor};
        OFS_MODE: st_nxt.rdata = {16'h0000, st_r.mode};
        OFS_PULSE_NUM: st_nxt.rdata = {9'h000, st_r.rev, st_r.pulse_num}; // see RL1
        OFS_PULSE_DEN: st_nxt.rdata = {12'h000, st_r.pulse_den};
        OFS_IRQ_EN: st_nxt.rdata = {23'h000000, st_r.irq_en};
        OFS_IRQ_STAT: st_nxt.rdata = {23'h000000, st_r.hf_stat};
        default: st_nxt.rdata = '0;
      endcase
    end

    if (reg_wr_in) begin
      case (reg_addr_in)
        OFS_DIVISOR: st_nxt.divisor = reg_wdata_in[DIV_W-1:0];
        OFS_MODE: st_nxt.mode = reg_wdata_in[7:0] & MODE_MASK;
        OFS_PULSE_NUM: st_nxt.pulse_num = reg_wdata_in[CF_W-1:0];
        OFS_PULSE_DEN: st_nxt.pulse_den = reg_wdata_in[CF_W-1:0];
        OFS_IRQ_EN: st_nxt.irq_en = reg_wdata_in[HALF_FULL_BIT];
        default: st_nxt.irq_en = st_r.irq_en;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_out = st_r.rdata;
  assign reg_rvalid_out = st_r.rvalid;
  assign half_full_irq_out = st_r.irq;
  assign cf_pulse_out = st_r.cf_pulse;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_clear_read;
    rd_clear;
  endsequence

  sequence s_half_cross;
    hf_now && !st_r.hf_prev;
  endsequence

  sequence s_irq_follow;
    st_r.hf_stat ##0 half_full_irq_out;
  endsequence

  chk_acc_period: assert property ( // see RL10
    (st_r.acc != $past(st_r.acc)) |-> ($past(add_now) || $past(rd_clear)))
    else $error("accumulator moved outside a sample slot");

  chk_acc_slots: assert property ( // see RL10
    add_now |=> !add_now [*3] ##1 add_now)
    else $error("sample slots are not four clocks apart");

  chk_signed_add: assert property ( // see RL11
    add_now && !rd_clear |=> st_r.acc == $past(st_r.acc) + $past(total_ext))
    else $error("signed accumulation wrong");

  chk_clear_zero: assert property ( // see RL14
    s_clear_read ##0 !add_now |=> st_r.acc == '0 && st_r.energy == '0)
    else $error("clear-on-read did not clear");

  chk_clear_keep: assert property ( // see RL21
    s_clear_read ##0 add_now |=> st_r.acc == $past(total_ext))
    else $error("sample lost at clear-on-read");

  chk_plain_read: assert property ( // see RL15
    rd_plain && !add_now |=> st_r.acc == $past(st_r.acc) ##0 reg_rvalid_out)
    else $error("plain read disturbed accumulator");

  chk_read_data: assert property ( // see RL14
    reg_rd_in && (hit(reg_addr_in, OFS_ENERGY) || hit(reg_addr_in, OFS_ENERGY_RC))
    |=> reg_rdata_out == $past(st_r.energy))
    else $error("energy read returned wrong value");

  chk_energy_upd: assert property ( // see RL13
    div_done && !rd_clear && !st_r.div_start
    |=> st_r.energy == $past(div_q[ACC_W-1:ACC_W-EN_W]))
    else $error("energy not upper quotient bits");

  chk_stale_drop: assert property ( // see RL14
    div_done && st_r.div_start && !rd_clear |=> st_r.energy == $past(st_r.energy))
    else $error("stale quotient reached energy after clear");

  chk_div_zero: assert property ( // see RL12
    st_r.divisor == '0 |-> div_eff == 8'h01)
    else $error("zero divisor not treated as one");

  chk_rev_mask: assert property ( // see RL3
    !en_a || !en_b || !en_c
    |=> (!st_r.rev[0] || $past(en_a)) && (!st_r.rev[1] || $past(en_b))
        && (!st_r.rev[2] || $past(en_c)))
    else $error("reverse bit set for excluded phase");

  chk_rev_sign: assert property ( // see RL2
    en_a |=> st_r.rev[0] == $past(pwr_a[TERM_W-1]))
    else $error("phase A reverse bit does not follow sign");

  chk_rev_sign_b: assert property ( // see RL2
    en_b |=> st_r.rev[1] == $past(pwr_b[TERM_W-1]))
    else $error("phase B reverse bit does not follow sign");

  chk_rev_sign_c: assert property ( // see RL2
    en_c |=> st_r.rev[2] == $past(pwr_c[TERM_W-1]))
    else $error("phase C reverse bit does not follow sign");

  chk_term_off: assert property ( // see RL6
    !en_b || !sum_form |-> term_b == '0)
    else $error("disabled term contributes");

  chk_half_irq: assert property ( // see RL17
    (st_r.irq_en and s_half_cross) |=> s_irq_follow)
    else $error("half-full interrupt missing");

  chk_irq_gate: assert property ( // see RL17
    !st_r.irq_en |=> !half_full_irq_out)
    else $error("interrupt raised while disabled");

  chk_stat_clear: assert property ( // see RL17
    rd_stat && !(hf_now && !st_r.hf_prev) |=> !st_r.hf_stat)
    else $error("half-full status not cleared by read");

  chk_read_valid: assert property ( // see RL15
    reg_rd_in |=> reg_rvalid_out)
    else $error("read answer missing one cycle after read");

  chk_pulse_idle: assert property ( // see RL20
    st_r.pend == '0 |=> !cf_pulse_out)
    else $error("pulse emitted with nothing pending");
endmodule // pae_accumulator

/* pkg/pae_pkg.sv */
package pae_pkg;
  // Datapath widths
  localparam int SAMP_W = 16;
  localparam int TERM_W = 34;
  localparam int ACC_W = 54;
  localparam int EN_W = 24;
  localparam int DIV_W = 8;
  localparam int CF_W = 12;
  localparam int ADDR_W = 4;

  // Register offsets
  localparam logic [3:0] OFS_ENERGY = 4'h0;
  localparam logic [3:0] OFS_ENERGY_RC = 4'h1;
  localparam logic [3:0] OFS_DIVISOR = 4'h2;
  localparam logic [3:0] OFS_MODE = 4'h3;
  localparam logic [3:0] OFS_PULSE_NUM = 4'h4;
  localparam logic [3:0] OFS_PULSE_DEN = 4'h5;
  localparam logic [3:0] OFS_IRQ_EN = 4'h6;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h7;

  // Field positions
  localparam int MODE_FORM_HI = 7;
  localparam int MODE_FORM_LO = 6;
  localparam int MODE_TERM_A = 5;
  localparam int MODE_TERM_B = 4;
  localparam int MODE_TERM_C = 3;
  localparam int REV_LO = 12;
  localparam int REV_HI = 14;
  localparam int HALF_FULL_BIT = 0;

  // Reset values and mode write mask
  localparam logic [7:0] MODE_RST = 8'h38;
  localparam logic [7:0] MODE_MASK = 8'hf8;
  localparam logic [7:0] DIVISOR_RST = 8'h00;
  localparam logic [11:0] PULSE_NUM_RST = 12'h000;
  localparam logic [11:0] PULSE_DEN_RST = 12'h000;
  localparam logic IRQ_EN_RST = 1'b0;

  // Formula codes
  localparam logic [1:0] FORM_SUM = 2'h0;
  localparam logic [1:0] FORM_DIFF = 2'h1;
  localparam logic [1:0] FORM_MIXED = 2'h2;

  // One accumulation every four input clocks
  localparam int ACC_PERIOD_CYC = 4;
  localparam logic [1:0] ACC_LAST = 2'(ACC_PERIOD_CYC - 1);

  typedef enum logic [1:0] {
    PAE_DIV_IDLE = 2'b01,
    PAE_DIV_RUN = 2'b10
  } pae_div_state_type;
endpackage

/* rtl/pae_divider.sv */
`timescale 1ns/1ps
module pae_divider #(
  parameter int N_W = 54,
  parameter int D_W = 8
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic [N_W-1:0] num_in,
  input wire logic [D_W-1:0] den_in,
  output logic [N_W-1:0] quot_out,
  output logic done_out
);
  import pae_pkg::*;

  typedef struct packed {
    pae_div_state_type phase;
    logic [6:0] cnt;
    logic [D_W:0] rem;
    logic [N_W-1:0] q;
    logic [D_W-1:0] den;
    logic neg;
    logic [N_W-1:0] quot;
    logic done;
  } pae_div_st_type;

  pae_div_st_type st_r;
  pae_div_st_type st_nxt;

  // Signed restoring division, one quotient bit per clock; start restarts
  always_comb begin
    logic [D_W:0] sh;
    logic [N_W-1:0] qn;
    sh = '0;
    qn = '0;
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (start_in) begin
      st_nxt.phase = PAE_DIV_RUN;
      st_nxt.neg = num_in[N_W-1];
      st_nxt.q = num_in[N_W-1] ? -num_in : num_in;
      st_nxt.rem = '0;
      st_nxt.den = den_in;
      st_nxt.cnt = 7'(N_W);
    end else begin
      case (st_r.phase)
        PAE_DIV_RUN: begin
          sh = {st_r.rem[D_W-1:0], st_r.q[N_W-1]};
          if (sh >= {1'b0, st_r.den}) begin
            st_nxt.rem = sh - {1'b0, st_r.den};
            qn = {st_r.q[N_W-2:0], 1'b1};
          end else begin
            st_nxt.rem = sh;
            qn = {st_r.q[N_W-2:0], 1'b0};
          end
          st_nxt.q = qn;
          st_nxt.cnt = st_r.cnt - 7'h01;
          if (st_r.cnt == 7'h01) begin
            st_nxt.phase = PAE_DIV_IDLE;
            st_nxt.done = 1'b1;
            st_nxt.quot = st_r.neg ? -qn : qn;
          end
        end
        default: st_nxt.phase = PAE_DIV_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_r <= '{phase: PAE_DIV_IDLE, den: 8'h01, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign quot_out = st_r.quot;
  assign done_out = st_r.done;
endmodule // pae_divider

/* testbench/pae_host_model.sv */
`timescale 1ns/1ps
module pae_host_model (
  input wire logic clk_in,
  output logic [pae_pkg::ADDR_W-1:0] reg_addr_out,
  output logic reg_rd_out,
  output logic reg_wr_out,
  output logic [pae_pkg::EN_W-1:0] reg_wdata_out
);
  import pae_pkg::*;
  initial begin
    reg_addr_out = '0;
    reg_rd_out = 1'b0;
    reg_wr_out = 1'b0;
    reg_wdata_out = '0;
  end
  // Phase gains never written; the testbench writes every offset from 0 to 9
  task automatic access(input logic [ADDR_W-1:0] a, input logic wr, input logic [EN_W-1:0] d);
    @(posedge clk_in);
    #1;
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_rd_out = !wr;
    reg_wr_out = wr;
    @(posedge clk_in);
    #1;
    reg_rd_out = 1'b0;
    reg_wr_out = 1'b0;
    // Idle bus must not keep showing the last word
    reg_addr_out = ~a;
    reg_wdata_out = ~d;
  endtask
endmodule // pae_host_model

/* testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import pae_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic signed [SAMP_W-1:0] va = '0;
  logic signed [SAMP_W-1:0] vb = '0;
  logic signed [SAMP_W-1:0] vc = '0;
  logic signed [SAMP_W-1:0] ia = '0;
  logic signed [SAMP_W-1:0] ib = '0;
  logic signed [SAMP_W-1:0] ic = '0;
  logic [ADDR_W-1:0] addr;
  logic rd_s;
  logic wr_s;
  logic [EN_W-1:0] wdata;
  logic [EN_W-1:0] rdata;
  logic rvalid;
  int cyc = 0;
  int tmo = 0;
  int mismatches = 0;
  int n_compared = 0;
  int seed = 78356;
  logic irq;
  logic cf;
  int cf_total = 0;
  logic [EN_W-1:0] exp_q[$];
  string name_q[$];
  // Wiring table per service, then formula 1 with B on and formula 3
  logic [7:0] modes [8] = '{8'h38, 8'h18, 8'h28, 8'h30, 8'h68, 8'ha8, 8'h78, 8'hf8};
  logic [EN_W-1:0] rst_tbl [10] = '{0, 0, 0, 24'h38, 0, 0, 0, 0, 0, 0};
  logic [EN_W-1:0] wr_tbl [10] = '{0, 0, 24'hff, 24'hf8, 24'hfff, 24'hfff, 24'h1, 0, 0, 0};

  always #10 clk_in = ~clk_in;

  pae_accumulator pae_accumulator_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .volt_a_in(va), .volt_b_in(vb), .volt_c_in(vc),
    .cur_a_in(ia), .cur_b_in(ib), .cur_c_in(ic),
    .reg_addr_in(addr), .reg_rd_in(rd_s), .reg_wr_in(wr_s), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .half_full_irq_out(irq), .cf_pulse_out(cf)
  );

  pae_host_model pae_host_model_i (
    .clk_in(clk_in), .reg_addr_out(addr), .reg_rd_out(rd_s),
    .reg_wr_out(wr_s), .reg_wdata_out(wdata)
  );

  function automatic longint pwr(input logic [7:0] m);
    longint ta;
    longint tb2;
    longint tc;
    ta = longint'(va) * longint'(ia);
    tb2 = longint'(vb) * longint'(ib);
    tc = longint'(vc) * longint'(ic);
    if (m[7:6] == FORM_DIFF || m[7:6] == FORM_MIXED) begin
      ta = longint'(va) * (longint'(ia) - longint'(ib));
      tb2 = 0;
    end
    if (m[7:6] == FORM_DIFF) begin
      tc = longint'(vc) * (longint'(ic) - longint'(ib));
    end
    return (m[MODE_TERM_A] ? ta : 0) + (m[MODE_TERM_B] ? tb2 : 0) + (m[MODE_TERM_C] ? tc : 0);
  endfunction

  function automatic logic [2:0] rev(input logic [7:0] m);
    return {m[MODE_TERM_C] & (longint'(vc) * longint'(ic) < 0),
            m[MODE_TERM_B] & (longint'(vb) * longint'(ib) < 0),
            m[MODE_TERM_A] & (longint'(va) * longint'(ia) < 0)};
  endfunction

  function automatic logic [EN_W-1:0] energy(input longint acc, input logic [7:0] d);
    longint q;
    q = acc / longint'((d == 8'h00) ? 8'h01 : d);
    return EN_W'(q >>> 30);
  endfunction

  task automatic report_and_stop;
    $display("mismatches=%0d n_compared=%0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check_word(input string n, input logic [EN_W-1:0] e, input logic [EN_W-1:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [EN_W-1:0] d);
    pae_host_model_i.access(a, 1'b1, d);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [EN_W-1:0] e, input string n);
    exp_q.push_back(e);
    name_q.push_back(n);
    pae_host_model_i.access(a, 1'b0, '0);
  endtask

  task automatic align(input int r);
    do begin
      @(posedge clk_in);
      #1;
    end while (cyc % ACC_PERIOD_CYC != r);
  endtask

  task automatic set_all(input logic signed [SAMP_W-1:0] v);
    va = v;
    vb = v;
    vc = v;
    ia = v;
    ib = v;
    ic = v;
  endtask

  task automatic run(input logic [7:0] m, input logic [7:0] d);
    longint acc;
    logic [EN_W-1:0] e;
    int cf0;
    cf0 = cf_total;
    wr(OFS_MODE, EN_W'(m));
    wr(OFS_DIVISOR, EN_W'(d));
    align(0);
    va = 16'($random(seed));
    vb = 16'($random(seed));
    vc = 16'($random(seed));
    ia = 16'($random(seed));
    ib = 16'($random(seed));
    ic = 16'($random(seed));
    acc = 32 * pwr(m);
    repeat (8) @(posedge clk_in);
    rd(OFS_PULSE_NUM, {9'h000, rev(m), 12'hfff}, "reverse bits");
    repeat (118) @(posedge clk_in);
    #1;
    set_all('0);
    repeat (250) @(posedge clk_in);
    e = energy(acc, d);
    rd(OFS_ENERGY, e, "energy");
    rd(OFS_ENERGY, e, "energy again");
    rd(OFS_ENERGY_RC, e, "energy read clear");
    repeat (250) @(posedge clk_in);
    rd(OFS_ENERGY, '0, "energy after clear");
    check_word("cf pulses", e[EN_W-1] ? -e : e, EN_W'(cf_total - cf0));
  endtask

  always @(posedge clk_in) begin
    cyc <= rst_n_in ? cyc + 1 : 0;
    tmo <= tmo + 1;
    if (tmo == 30000) begin
      mismatches++;
      report_and_stop();
    end
  end

  always @(negedge clk_in) begin
    if (cf === 1'b1) begin
      cf_total++;
    end
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("ERROR read answer expected none seen %h", rdata);
      end else begin
        check_word(name_q.pop_front(), exp_q.pop_front(), rdata);
      end
    end
  end

  initial begin
    repeat (10) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    for (int a = 0; a < 10; a++) begin
      rd(4'(a), rst_tbl[a], "reset value");
    end
    for (int a = 0; a < 10; a++) begin
      wr(4'(a), '1);
      rd(4'(a), wr_tbl[a], "write then read");
    end
    for (int i = 0; i < 16; i++) begin
      run(modes[i % 8], (i < 8) ? 8'(i) : 8'($random(seed)));
    end
    // Second reset in mid-run; every register returns to its reset value
    rst_n_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    for (int a = 0; a < 10; a++) begin
      rd(4'(a), rst_tbl[a], "reset again");
    end
    // Clear-on-read taken on the very edge that adds a sample
    wr(OFS_IRQ_EN, 24'h000001);
    wr(OFS_MODE, 24'h38);
    wr(OFS_DIVISOR, 24'h01);
    align(2);
    set_all(16'sh7fff);
    rd(OFS_ENERGY_RC, '0, "clear with sample");
    set_all('0);
    repeat (250) @(posedge clk_in);
    rd(OFS_ENERGY, energy(3 * 64'sd1073676289, 8'h01), "sample kept");
    rd(OFS_IRQ_STAT, '0, "half-full status");
    check_word("half-full irq", '0, {23'h000000, irq});
    repeat (4) @(posedge clk_in);
    if (exp_q.size() != 0) begin
      mismatches++;
      $display("ERROR read answers expected %0d seen 0", exp_q.size());
    end
    report_and_stop();
  end
endmodule // tb_top
